// ===== dli_pkg.sv
// Constants shared by the diagnostic LED indicator
package dli_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_UNITS = 8;
  localparam int CODE_W = 4;
  localparam int CNT_W = 32;
  // ---------------------------------------------------------------
  // Unit error codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_BOARD_POWER = 4'h1;
  localparam logic [3:0] CODE_ARRAY_CFG = 4'h6;
  localparam logic [3:0] CODE_COOL_FAN = 4'hA;
  localparam logic [3:0] CODE_LDU_ILOCK = 4'hB;
  localparam logic [3:0] CODE_BOARD_OVERTEMP = 4'hC;
  localparam logic [3:0] CODE_AUTO_FIRST = 4'hD;
  localparam logic [3:0] CODE_AUTO_LAST = 4'hF;
  // ---------------------------------------------------------------
  // Supervisor categories
  // ---------------------------------------------------------------
  localparam logic [3:0] CAT_NONE = 4'h0;
  localparam logic [3:0] CAT_LAST_DEFINED = 4'hA;
  // ---------------------------------------------------------------
  // Startup timing at 100 MHz
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int FLASH_MS = 500;
  localparam int DARK_MS = 3000;
  localparam logic [31:0] FLASH_CYCLES = 32'(FLASH_MS * CLK_KHZ);
  localparam logic [31:0] DARK_CYCLES = 32'(DARK_MS * CLK_KHZ);
  // ---------------------------------------------------------------
  // Front panel LED positions and startup states
  // ---------------------------------------------------------------
  localparam int FP_LASER = 0;
  localparam int FP_OVERTEMP = 1;
  localparam int FP_ILOCK = 2;
  localparam int FP_FAILURE = 3;
  localparam logic [3:0] FP_ALL_ON = 4'hF;
  localparam logic [3:0] FP_ALL_OFF = 4'h0;
  typedef enum logic [1:0] {ST_FLASH, ST_DARK, ST_RUN} dli_phase_e;
endpackage : dli_pkg

// ===== dli_indicator.sv
// Diagnostic LED indicator: unit code LEDs, supervisor LEDs, front panel
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
module dli_indicator #(
  parameter logic [31:0] P_FLASH_CYCLES = dli_pkg::FLASH_CYCLES,
  parameter logic [31:0] P_DARK_CYCLES = dli_pkg::DARK_CYCLES
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Drive unit reports
  input wire logic [4*dli_pkg::NUM_UNITS-1:0] I_LDU_CODE,
  input wire logic [dli_pkg::NUM_UNITS-1:0] I_LDU_LASER_ON,
  input wire logic [dli_pkg::NUM_UNITS-1:0] I_LDU_OVERTEMP,
  // Cooling unit reports
  input wire logic [4*dli_pkg::NUM_UNITS-1:0] I_COOL_CODE,
  input wire logic [dli_pkg::NUM_UNITS-1:0] I_COOL_OVERTEMP,
  // Supervisor status
  input wire logic [3:0] I_SSU_CATEGORY,
  input wire logic I_ILOCK_OPEN,
  input wire logic I_FAULT_BUF_NONEMPTY,
  input wire logic I_CHIP_CARD_FAULT,
  input wire logic I_NOT_LOCAL_EVT,
  input wire logic I_LOCAL_MODE,
  input wire logic I_FAULT_QUERY,
  // Unit LEDs and flags
  output logic [4*dli_pkg::NUM_UNITS-1:0] O_LDU_LED,
  output logic [dli_pkg::NUM_UNITS-1:0] O_LDU_FAIL,
  output logic [dli_pkg::NUM_UNITS-1:0] O_LDU_AUTORST,
  output logic [4*dli_pkg::NUM_UNITS-1:0] O_COOL_LED,
  output logic [dli_pkg::NUM_UNITS-1:0] O_COOL_FAIL,
  output logic [dli_pkg::NUM_UNITS-1:0] O_COOL_AUTORST,
  // Decoded fault classes
  output logic O_COMMON_FAULT,
  output logic O_FAN_FAULT,
  output logic O_LASER_ILOCK_FAULT,
  // Supervisor and front panel LEDs
  output logic [3:0] O_SSU_LED,
  output logic O_SSU_CAT_UNDEF,
  output logic [3:0] O_FRONT_LED,
  output logic O_NOT_LOCAL_PEND
);
  import dli_pkg::*;

  // ---------------------------------------------------------------
  // Assertion helper
  // ---------------------------------------------------------------
  // The flops keep their reset values through the release edge, so checks
  // that look one cycle back and are gated on armed wait until a whole cycle has run out of reset
  logic armed;
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Per unit decoding
  // ---------------------------------------------------------------
  logic [NUM_UNITS-1:0] ldu_nz, ldu_auto, ldu_common, ldu_ilock, ldu_ot;
  logic [NUM_UNITS-1:0] cool_nz, cool_auto, cool_common, cool_fan, cool_ot;

  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g++) begin : g_unit
      wire logic [3:0] lc = I_LDU_CODE[4*g +: 4];
      wire logic [3:0] ac = I_COOL_CODE[4*g +: 4];
      assign ldu_nz[g] = (lc != CODE_NONE);
      assign cool_nz[g] = (ac != CODE_NONE);
      assign ldu_auto[g] = (lc >= CODE_AUTO_FIRST) && (lc <= CODE_AUTO_LAST);
      assign cool_auto[g] = (ac >= CODE_AUTO_FIRST) && (ac <= CODE_AUTO_LAST);
      assign ldu_common[g] = (lc >= CODE_BOARD_POWER) && (lc <= CODE_ARRAY_CFG);
      assign cool_common[g] = (ac >= CODE_BOARD_POWER) && (ac <= CODE_ARRAY_CFG);
      assign ldu_ilock[g] = (lc == CODE_LDU_ILOCK);
      assign cool_fan[g] = (ac == CODE_COOL_FAN);
      // A unit whose code says overtemperature counts even if its status bit was missed
      assign ldu_ot[g] = I_LDU_OVERTEMP[g] || (lc == CODE_BOARD_OVERTEMP);
      assign cool_ot[g] = I_COOL_OVERTEMP[g] || (ac == CODE_BOARD_OVERTEMP);

      always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          O_LDU_FAIL[g] <= 1'b0;
          O_COOL_FAIL[g] <= 1'b0;
          O_LDU_AUTORST[g] <= 1'b0;
          O_COOL_AUTORST[g] <= 1'b0;
        end else begin
          O_LDU_FAIL[g] <= ldu_nz[g];
          O_COOL_FAIL[g] <= cool_nz[g];
          O_LDU_AUTORST[g] <= ldu_auto[g];
          O_COOL_AUTORST[g] <= cool_auto[g];
        end
      end

      unit_fail_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        O_LDU_FAIL[g] == ($past(I_LDU_CODE[4*g +: 4]) != 4'h0))
        else $error("drive unit failure flag does not match code");
      unit_autorst_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        O_COOL_AUTORST[g] == ($past(I_COOL_CODE[4*g +: 4]) >= 4'hD))
        else $error("cooling unit auto-reset mark wrong");
      cool_fail_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        armed |-> (O_COOL_FAIL[g] == ($past(I_COOL_CODE[4*g +: 4]) != 4'h0)))
        else $error("cooling unit failure flag does not match code");
      drive_autorst_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        armed |-> (O_LDU_AUTORST[g] == ($past(I_LDU_CODE[4*g +: 4]) >= 4'hD)))
        else $error("drive unit auto-reset mark wrong");
      fan_class_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_COOL_CODE[4*g +: 4] == 4'hA) |=> O_FAN_FAULT)
        else $error("fan code not flagged");
      common_class_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        ((I_LDU_CODE[4*g +: 4] >= 4'h1) && (I_LDU_CODE[4*g +: 4] <= 4'h6)) |=> O_COMMON_FAULT)
        else $error("common code not flagged");
      ilock_class_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (I_LDU_CODE[4*g +: 4] == 4'hB) |=> O_LASER_ILOCK_FAULT)
        else $error("interlock-while-on code not flagged");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Unit code LEDs and fault classes
  // ---------------------------------------------------------------
  // The code is already binary with bit 0 on LED1, so it drives the LEDs as is
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_LDU_LED <= '0;
      O_COOL_LED <= '0;
      O_COMMON_FAULT <= 1'b0;
      O_FAN_FAULT <= 1'b0;
      O_LASER_ILOCK_FAULT <= 1'b0;
    end else begin
      O_LDU_LED <= I_LDU_CODE;
      O_COOL_LED <= I_COOL_CODE;
      O_COMMON_FAULT <= |{ldu_common, cool_common};
      O_FAN_FAULT <= |cool_fan;
      O_LASER_ILOCK_FAULT <= |ldu_ilock;
    end
  end

  unit_led_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    O_COOL_LED == $past(I_COOL_CODE))
    else $error("cooling unit LEDs do not show the code");
  drive_led_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    armed |-> (O_LDU_LED == $past(I_LDU_CODE)))
    else $error("drive unit LEDs do not show the code");

  // ---------------------------------------------------------------
  // Supervisor category LEDs
  // ---------------------------------------------------------------
  wire logic cat_undef = (I_SSU_CATEGORY > CAT_LAST_DEFINED);

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SSU_LED <= CAT_NONE;
      O_SSU_CAT_UNDEF <= 1'b0;
    end else begin
      O_SSU_LED <= I_SSU_CATEGORY;
      O_SSU_CAT_UNDEF <= cat_undef;
    end
  end

  ssu_led_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    O_SSU_LED == $past(I_SSU_CATEGORY))
    else $error("supervisor LEDs do not show the category");
  ssu_undef_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    armed |-> (O_SSU_CAT_UNDEF == ($past(I_SSU_CATEGORY) > 4'hA)))
    else $error("undefined category flag wrong");

  // ---------------------------------------------------------------
  // Interlock sense synchroniser
  // ---------------------------------------------------------------
  logic ilock_meta, ilock_sync;
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ilock_meta <= 1'b0;
      ilock_sync <= 1'b0;
    end else begin
      ilock_meta <= I_ILOCK_OPEN;
      ilock_sync <= ilock_meta;
    end
  end

  // ---------------------------------------------------------------
  // Not-in-local-mode latch
  // ---------------------------------------------------------------
  logic local_prev;
  wire logic local_enter = I_LOCAL_MODE && !local_prev;
  wire logic nl_clear = local_enter || I_FAULT_QUERY;
  // A new event in the clearing cycle is kept: set wins
  wire logic next_nl_pend = I_NOT_LOCAL_EVT || (O_NOT_LOCAL_PEND && !nl_clear);

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      local_prev <= 1'b0;
      O_NOT_LOCAL_PEND <= 1'b0;
    end else begin
      local_prev <= I_LOCAL_MODE;
      O_NOT_LOCAL_PEND <= next_nl_pend;
    end
  end

  nl_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (I_FAULT_QUERY && !I_NOT_LOCAL_EVT) |=> !O_NOT_LOCAL_PEND)
    else $error("not-local event survived a fault query");
  nl_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    I_NOT_LOCAL_EVT |=> O_NOT_LOCAL_PEND)
    else $error("not-local event lost");
  local_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (armed && $rose(I_LOCAL_MODE) && !I_NOT_LOCAL_EVT) |=> !O_NOT_LOCAL_PEND)
    else $error("not-local event survived entering local mode");
  pend_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (O_NOT_LOCAL_PEND && !I_FAULT_QUERY && !I_LOCAL_MODE) |=> O_NOT_LOCAL_PEND)
    else $error("not-local event dropped without a clear");

  // ---------------------------------------------------------------
  // Startup sequencer
  // ---------------------------------------------------------------
  dli_phase_e phase, next_phase;
  logic [CNT_W-1:0] cnt;
  wire logic cnt_done = (phase == ST_FLASH) ? (cnt >= P_FLASH_CYCLES - 32'h1)
                                            : (cnt >= P_DARK_CYCLES - 32'h1);
  wire logic [CNT_W-1:0] next_cnt = (cnt_done || phase == ST_RUN) ? '0 : cnt + 32'h1;

  always_comb begin
    next_phase = phase;
    case (phase)
      ST_FLASH: if (cnt_done) next_phase = ST_DARK;
      ST_DARK: if (cnt_done) next_phase = ST_RUN;
      default: next_phase = ST_RUN;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase <= ST_FLASH;
      cnt <= '0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Front panel LEDs
  // ---------------------------------------------------------------
  logic [3:0] live;
  assign live[FP_LASER] = |I_LDU_LASER_ON;
  assign live[FP_OVERTEMP] = |{ldu_ot, cool_ot};
  assign live[FP_ILOCK] = ilock_sync;
  assign live[FP_FAILURE] = I_FAULT_BUF_NONEMPTY || I_CHIP_CARD_FAULT || O_NOT_LOCAL_PEND;

  wire logic [3:0] next_front = (phase == ST_FLASH) ? FP_ALL_ON
                              : (phase == ST_DARK) ? FP_ALL_OFF : live;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FRONT_LED <= FP_ALL_OFF;
    end else begin
      O_FRONT_LED <= next_front;
    end
  end

  dli_phase_e phase_prev;
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase_prev <= ST_FLASH;
    end else begin
      phase_prev <= phase;
    end
  end
  // This cycle and the one before in run, so the front LEDs have left startup
  wire logic run_two = (phase == ST_RUN) && (phase_prev == ST_RUN);

  dark_phase_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (phase == ST_DARK) |=> (O_FRONT_LED == 4'h0))
    else $error("front LEDs lit during dark phase");
  flash_phase_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (armed && (phase == ST_FLASH)) |=> (O_FRONT_LED == 4'hF))
    else $error("front LEDs not flashing at startup");
  laser_led_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    run_two |-> (O_FRONT_LED[0] == $past(|I_LDU_LASER_ON)))
    else $error("laser-on LED wrong");
  overtemp_led_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (run_two && $past(|{I_LDU_OVERTEMP, I_COOL_OVERTEMP})) |-> O_FRONT_LED[1])
    else $error("overtemperature LED dark");
  ilock_led_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    run_two |-> (O_FRONT_LED[2] == $past(I_ILOCK_OPEN, 3)))
    else $error("interlock LED does not follow the sense");
  failure_led_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    run_two |-> (O_FRONT_LED[3] == $past(I_FAULT_BUF_NONEMPTY || I_CHIP_CARD_FAULT || O_NOT_LOCAL_PEND)))
    else $error("failure LED wrong");
  run_stays_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    (phase == ST_RUN) |=> (phase == ST_RUN))
    else $error("startup phase entered again after run");

endmodule : dli_indicator

// ===== dli_unit_model.sv
// Far-side model of the drive and cooling units sending their error codes
`timescale 1ns/1ps
module dli_unit_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Report request from the bench
  input wire logic i_set,
  input wire logic [2:0] i_unit,
  input wire logic [3:0] i_ldu,
  input wire logic [3:0] i_cool,
  // Reported codes, unit n in nibble n
  output logic [31:0] o_ldu_code,
  output logic [31:0] o_cool_code
);
  // A new report replaces all others, so at most one unit carries a code at a time
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ldu_code <= 32'h0;
      o_cool_code <= 32'h0;
    end else if (i_set) begin
      o_ldu_code <= 32'(i_ldu) << (4 * i_unit);
      o_cool_code <= 32'(i_cool) << (4 * i_unit);
    end
  end
endmodule : dli_unit_model

// ===== diagnostic_led_indicator_test.sv
// Self-checking bench for the diagnostic LED indicator
`timescale 1ns/1ps
module diagnostic_led_indicator_test;
  import dli_pkg::*;
  logic I_CLOCK = 1'b0, I_RST_N = 1'b0, set = 1'b0;
  logic [2:0] unit = 3'h0;
  logic [3:0] code = 4'h0, cat = 4'h0;
  logic [31:0] ldu_code, cool_code, ldu_led, cool_led;
  logic [7:0] laser = 8'h0, ldu_ot = 8'h0, cool_ot = 8'h0, ldu_fail, ldu_ar, cool_fail, cool_ar;
  logic ilock = 1'b0, fbuf = 1'b0, card = 1'b0, evt = 1'b0, local_mode = 1'b0, query = 1'b0;
  logic common, fan, lil, undef, pend;
  logic [3:0] ssu_led, front;
  int err_count = 0, cmp_count = 0, n;
  dli_unit_model model (.i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_set(set), .i_unit(unit), .i_ldu(code),
    .i_cool(code), .o_ldu_code(ldu_code), .o_cool_code(cool_code));
  dli_indicator #(.P_FLASH_CYCLES(32'h4), .P_DARK_CYCLES(32'h8)) dut (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
    .I_LDU_CODE(ldu_code), .I_LDU_LASER_ON(laser), .I_LDU_OVERTEMP(ldu_ot), .I_COOL_CODE(cool_code),
    .I_COOL_OVERTEMP(cool_ot), .I_SSU_CATEGORY(cat), .I_ILOCK_OPEN(ilock), .I_FAULT_BUF_NONEMPTY(fbuf),
    .I_CHIP_CARD_FAULT(card), .I_NOT_LOCAL_EVT(evt), .I_LOCAL_MODE(local_mode), .I_FAULT_QUERY(query),
    .O_LDU_LED(ldu_led), .O_LDU_FAIL(ldu_fail), .O_LDU_AUTORST(ldu_ar), .O_COOL_LED(cool_led),
    .O_COOL_FAIL(cool_fail), .O_COOL_AUTORST(cool_ar), .O_COMMON_FAULT(common), .O_FAN_FAULT(fan),
    .O_LASER_ILOCK_FAULT(lil), .O_SSU_LED(ssu_led), .O_SSU_CAT_UNDEF(undef), .O_FRONT_LED(front),
    .O_NOT_LOCAL_PEND(pend));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    forever #5 I_CLOCK = ~I_CLOCK;
  end
  task step(input int k);
    repeat (k) @(posedge I_CLOCK);
    #1;
  endtask : step
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Laser stays reported on through startup, so a premature live front panel shows up
  task test_startup;
    @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    step(1);
    for (n = 0; n < 100 && front === FP_ALL_ON; n++) step(1);
    chk("flash cycles", 32'h4, n);
    for (n = 0; n < 100 && front === FP_ALL_OFF; n++) step(1);
    chk("dark cycles", 32'h8, n);
    chk("front live", 32'h1, 32'(front));
    @(posedge I_CLOCK);
    laser <= 8'h0;
    step(1);
    chk("front laser off", 32'h0, 32'(front));
    $display("startup test done");
  endtask : test_startup
  // Every code in turn, on unit c mod 8 so each unit is used twice, both unit types at once
  task test_codes;
    for (int c = 0; c < 16; c++) begin
      @(posedge I_CLOCK);
      set <= 1'b1;
      unit <= 3'(c);
      code <= 4'(c);
      @(posedge I_CLOCK);
      set <= 1'b0;
      step(1);
      chk("drive leds", 32'(c) << (4 * (c % 8)), ldu_led);
      chk("cooling leds", 32'(c) << (4 * (c % 8)), cool_led);
      chk("drive fail", 32'(c != 0) << (c % 8), 32'(ldu_fail));
      chk("cooling fail", 32'(c != 0) << (c % 8), 32'(cool_fail));
      chk("drive autorst", 32'(c >= 13) << (c % 8), 32'(ldu_ar));
      chk("cooling autorst", 32'(c >= 13) << (c % 8), 32'(cool_ar));
      chk("common fault", 32'(c >= 1 && c <= 6), 32'(common));
      chk("fan fault", 32'(c == 10), 32'(fan));
      chk("interlock fault", 32'(c == 11), 32'(lil));
      chk("front overtemp code", 32'(c == 12) << FP_OVERTEMP, 32'(front));
    end
    $display("unit code test done");
  endtask : test_codes
  task test_categories;
    for (int c = 15; c >= 0; c--) begin
      @(posedge I_CLOCK);
      cat <= 4'(c);
      step(1);
      chk("supervisor leds", 32'(c), 32'(ssu_led));
      chk("undefined category", 32'(c > 10), 32'(undef));
    end
    $display("category test done");
  endtask : test_categories
  task test_front;
    @(posedge I_CLOCK);
    laser <= 8'h80;
    step(1);
    chk("front laser", 32'h1, 32'(front));
    @(posedge I_CLOCK);
    laser <= 8'h0;
    cool_ot <= 8'h08;
    step(1);
    chk("front cooling overtemp", 32'h2, 32'(front));
    @(posedge I_CLOCK);
    cool_ot <= 8'h0;
    ldu_ot <= 8'h01;
    step(1);
    chk("front ldu overtemp", 32'h2, 32'(front));
    @(posedge I_CLOCK);
    ldu_ot <= 8'h0;
    ilock <= 1'b1;
    step(3);
    chk("front interlock", 32'h4, 32'(front));
    @(posedge I_CLOCK);
    ilock <= 1'b0;
    fbuf <= 1'b1;
    step(3);
    chk("front fault buffer", 32'h8, 32'(front));
    @(posedge I_CLOCK);
    fbuf <= 1'b0;
    card <= 1'b1;
    step(1);
    chk("front chip card", 32'h8, 32'(front));
    @(posedge I_CLOCK);
    card <= 1'b0;
    step(1);
    chk("front clear", 32'h0, 32'(front));
    $display("front panel test done");
  endtask : test_front
  // Pending event: set, set beats clear, clear by query, clear by entering local mode
  task test_latch;
    @(posedge I_CLOCK);
    evt <= 1'b1;
    @(posedge I_CLOCK);
    evt <= 1'b0;
    step(1);
    chk("pending set", 32'h1, 32'(pend));
    chk("front failure", 32'h8, 32'(front));
    @(posedge I_CLOCK);
    evt <= 1'b1;
    query <= 1'b1;
    step(1);
    chk("set beats query", 32'h1, 32'(pend));
    @(posedge I_CLOCK);
    evt <= 1'b0;
    step(1);
    chk("pending after query", 32'h0, 32'(pend));
    @(posedge I_CLOCK);
    query <= 1'b0;
    evt <= 1'b1;
    @(posedge I_CLOCK);
    evt <= 1'b0;
    local_mode <= 1'b1;
    step(0);
    chk("pending before local", 32'h1, 32'(pend));
    step(1);
    chk("pending after local", 32'h0, 32'(pend));
    step(1);
    chk("front after clear", 32'h0, 32'(front));
    @(posedge I_CLOCK);
    local_mode <= 1'b0;
    $display("not-local latch test done");
  endtask : test_latch
  initial begin
    laser <= 8'h01;
    repeat (10) @(posedge I_CLOCK);
    test_startup();
    test_codes();
    test_categories();
    test_front();
    test_latch();
    end_of_test();
  end
  // Whole run is well under 400 cycles
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule : diagnostic_led_indicator_test
